// [core/flru_pkg.sv]
// Package for the fault limit and response unit: codes, resets, types, linear helper
package flru_pkg;
  localparam int CLK_MHZ = 200;
  // Command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_UV_RESP = 8'h45;
  localparam logic [7:0] CMD_OC_LIMIT = 8'h46;
  localparam logic [7:0] CMD_UC_LIMIT = 8'h4b;
  localparam logic [7:0] CMD_OT_LIMIT = 8'h4f;
  localparam logic [7:0] CMD_OT_RESP = 8'h50;
  localparam logic [7:0] CMD_WARN_LIMIT = 8'h51;
  // Reset values
  localparam logic [7:0] RST_RESP = 8'h80;
  localparam logic [15:0] RST_OC_LIMIT = 16'hdb00;
  localparam logic [15:0] RST_UC_LIMIT = 16'hdd00;
  localparam logic [15:0] RST_OT_LIMIT = 16'hebe8;
  localparam logic [15:0] RST_WARN_LIMIT = 16'heb70;
  // Response field codes
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DELAY = 2'h1;
  localparam logic [1:0] RESP_DISABLE = 2'h2;
  localparam logic [1:0] RESP_HOLD = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  // Fixed-point compare domain
  localparam int FIX_FRAC = 16;
  localparam logic signed [47:0] ILIM_MAX = 48'sh0018_0000;
  localparam logic signed [47:0] ILIM_MIN = -48'sh0018_0000;
  localparam logic signed [47:0] TEMP_MIN = 48'sh0000_0000;
  localparam logic signed [47:0] TEMP_MAX = 48'sh00af_0000;
  typedef struct packed {logic [1:0] mode; logic [2:0] retry; logic [2:0] dtime;} flru_resp_t;
  typedef struct packed {logic valid; logic write; logic [7:0] code; logic [15:0] wdata;} flru_cmd_t;
  typedef struct packed {
    logic temperature; logic ot_fault; logic ot_warning; logic oc_fault; logic uc_fault; logic uv_fault;
  } flru_status_t;
  // Linear word to signed fixed point with FIX_FRAC fraction bits
  function automatic logic signed [47:0] lin_to_fix(input logic [15:0] w);
    logic signed [5:0] e;
    logic signed [47:0] m;
    logic [5:0] sh;
    e = 6'($signed(w[15:11]));
    m = 48'($signed(w[10:0]));
    sh = 6'(e + 6'(FIX_FRAC));
    return m <<< sh;
  endfunction
endpackage

// [core/flru_sample_filt.sv]
// Consecutive-sample filter for blanked current samples
`timescale 1ns/100ps
module flru_sample_filt import flru_pkg::*; #(
  parameter int CW = 4
) (
  input wire logic sys_clk, // System clock
  input wire logic arst_n, // Async reset, low
  input wire logic sample_valid, // New current sample
  input wire logic blank_done, // Blanking interval over
  input wire logic exceed, // Sample beyond limit
  input wire logic [CW-1:0] need, // Consecutive count needed
  output logic trip // Fault declared
);
  logic [CW-1:0] run;
  logic [CW-1:0] goal;
  assign goal = (need == '0) ? CW'(1) : need;
  // Count only samples taken after blanking
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      run <= '0;
      trip <= 1'b0;
    end else if (sample_valid && blank_done) begin
      if (!exceed) begin
        run <= '0;
        trip <= 1'b0;
      end else begin
        if (run != '1) run <= run + CW'(1);
        // A saturated count must keep the trip up
        trip <= (run == '1) || ((run + CW'(1)) >= goal);
      end
    end
  end
endmodule // flru_sample_filt

// [core/flru_resp_seq.sv]
// Fault response sequencer: ignore, delay, disable, hold, retry
`timescale 1ns/100ps
module flru_resp_seq import flru_pkg::*; #(
  parameter int UNIT_CYC = 200
) (
  input wire logic sys_clk, // System clock
  input wire logic arst_n, // Async reset, low
  input wire logic fault, // Fault present
  input wire logic restart, // Device restart pulse
  input wire flru_resp_t resp, // Response setting
  output logic run_ok // Output permitted
);
  typedef enum logic [2:0] {S_RUN, S_DELAY, S_WAIT, S_HOLD, S_LATCH} flru_seq_state_t;
  flru_seq_state_t state;
  logic [31:0] timer;
  logic [31:0] span;
  logic [2:0] used;
  logic give_up;
  // Time count scaled by the per-fault unit
  assign span = (resp.dtime == '0) ? 32'h0000_0001 : 32'(resp.dtime) * 32'(UNIT_CYC);
  assign give_up = (resp.retry == RETRY_NONE) || (resp.retry != RETRY_FOREVER && used >= resp.retry);
  assign run_ok = (state == S_RUN) || (state == S_DELAY);
  // Sequencer state, timer and attempt count
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_RUN;
      timer <= '0;
      used <= '0;
    end else if (restart) begin
      state <= S_RUN;
      used <= '0;
    end else begin
      unique case (state)
        S_RUN: if (fault) begin
          unique case (resp.mode)
            RESP_IGNORE: state <= S_RUN;
            RESP_DELAY: begin
              state <= S_DELAY;
              timer <= span;
            end
            RESP_DISABLE: begin
              state <= give_up ? S_LATCH : S_WAIT;
              timer <= span;
            end
            RESP_HOLD: state <= S_HOLD;
          endcase
        end
        S_DELAY: if (timer <= 32'h0000_0001) begin
          state <= give_up ? S_LATCH : S_WAIT;
          timer <= span;
        end else timer <= timer - 32'h0000_0001;
        S_WAIT: if (timer <= 32'h0000_0001) begin
          state <= S_RUN;
          if (resp.retry != RETRY_FOREVER) used <= used + 3'h1;
        end else timer <= timer - 32'h0000_0001;
        S_HOLD: if (!fault) state <= S_RUN;
        S_LATCH: state <= S_LATCH;
      endcase
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  ignore_keeps_run_a: assert property (state == S_RUN && fault && resp.mode == RESP_IGNORE && !restart
    |=> run_ok) else $error("ignored fault stopped output");
  disable_now_a: assert property (state == S_RUN && fault && resp.mode == RESP_DISABLE && !restart
    |=> !run_ok) else $error("disable mode kept output on");
  hold_release_a: assert property (state == S_HOLD && !fault && !restart |=> state == S_RUN)
    else $error("hold did not release");
  latch_stays_a: assert property (state == S_LATCH && !restart |=> state == S_LATCH)
    else $error("latched off left without restart");
  cover_retry_c: cover property (state == S_WAIT ##1 state == S_RUN);
  cover_latch_c: cover property (state == S_DELAY ##1 state == S_LATCH);
endmodule // flru_resp_seq

// [core/flru_unit.sv]
// Fault limit and response unit top: command registers, comparators, status, output enable
`timescale 1ns/100ps
module flru_unit import flru_pkg::*; #(
  parameter int UV_UNIT_US = 1,
  parameter int OT_UNIT_US = 1000,
  parameter int UV_UNIT_CYC = UV_UNIT_US * CLK_MHZ,
  parameter int OT_UNIT_CYC = OT_UNIT_US * CLK_MHZ,
  parameter int CNT_W = 4
) (
  input wire logic sys_clk, // System clock
  input wire logic arst_n, // Async reset, low
  input wire flru_cmd_t cmd, // Host command request
  output logic rsp_valid, // Command answered
  output logic [15:0] rsp_data, // Read data
  output logic rsp_err, // Unknown code or bad value
  input wire logic [15:0] iout_sample, // Current sample, linear
  input wire logic iout_valid, // Current sample strobe
  input wire logic blank_done, // Sense blanking over
  input wire logic [CNT_W-1:0] oc_sample_count, // Count field of vendor_configuration_word
  input wire logic [15:0] temp_sample, // Temperature sample, linear
  input wire logic temp_valid, // Temperature sample strobe
  input wire logic vout_uv_pin, // Undervoltage comparator, async
  input wire logic out_enable_req, // Output enable request
  input wire logic out_ramping, // Output is ramping
  output logic out_enable, // Output enable to power stage
  output flru_status_t status, // Sticky status bits
  output logic host_alert // Host notification level
);
  // Command registers
  flru_resp_t uv_resp;
  flru_resp_t ot_resp;
  logic [15:0] oc_limit;
  logic [15:0] uc_limit;
  logic [15:0] ot_limit;
  logic [15:0] warn_limit;
  // Decoded write strobes and range checks
  logic wr;
  logic rd;
  logic signed [47:0] wfix;
  logic cur_ok;
  logic tmp_ok;
  logic known;
  logic clear_cmd;
  // Measurement path
  logic uv_meta;
  logic uv_sync;
  logic uv_fault;
  logic signed [47:0] ifix;
  logic signed [47:0] tfix;
  logic oc_exceed;
  logic uc_exceed;
  logic oc_trip;
  logic uc_trip;
  logic ot_active;
  logic warn_active;
  logic uv_ok;
  logic ot_ok;
  logic req_q;
  logic restart;
  flru_status_t next_status;

  assign wr = cmd.valid && cmd.write;
  assign rd = cmd.valid && !cmd.write;
  assign wfix = lin_to_fix(cmd.wdata);
  assign cur_ok = (wfix >= ILIM_MIN) && (wfix <= ILIM_MAX);
  assign tmp_ok = (wfix >= TEMP_MIN) && (wfix <= TEMP_MAX);
  assign clear_cmd = wr && cmd.code == CMD_CLEAR_FAULTS;

  // Known command codes
  always_comb begin
    unique case (cmd.code)
      CMD_CLEAR_FAULTS, CMD_UV_RESP, CMD_OC_LIMIT, CMD_UC_LIMIT, CMD_OT_LIMIT, CMD_OT_RESP, CMD_WARN_LIMIT:
        known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // Response bytes, low byte of the write data
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      uv_resp <= RST_RESP;
      ot_resp <= RST_RESP;
    end else if (wr) begin
      if (cmd.code == CMD_UV_RESP) uv_resp <= cmd.wdata[7:0];
      if (cmd.code == CMD_OT_RESP) ot_resp <= cmd.wdata[7:0];
    end
  end

  // Current limit words, out-of-range writes refused
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      oc_limit <= RST_OC_LIMIT;
      uc_limit <= RST_UC_LIMIT;
    end else if (wr && cur_ok) begin
      if (cmd.code == CMD_OC_LIMIT) oc_limit <= cmd.wdata;
      if (cmd.code == CMD_UC_LIMIT) uc_limit <= cmd.wdata;
    end
  end

  // Temperature limit words, out-of-range writes refused
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ot_limit <= RST_OT_LIMIT;
      warn_limit <= RST_WARN_LIMIT;
    end else if (wr && tmp_ok) begin
      if (cmd.code == CMD_OT_LIMIT) ot_limit <= cmd.wdata;
      if (cmd.code == CMD_WARN_LIMIT) warn_limit <= cmd.wdata;
    end
  end

  // Command answer one cycle after the request
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_err <= 1'b0;
    end else begin
      rsp_valid <= cmd.valid;
      rsp_data <= '0;
      rsp_err <= cmd.valid && !known;
      if (wr && (cmd.code == CMD_OC_LIMIT || cmd.code == CMD_UC_LIMIT) && !cur_ok) rsp_err <= 1'b1;
      if (wr && (cmd.code == CMD_OT_LIMIT || cmd.code == CMD_WARN_LIMIT) && !tmp_ok) rsp_err <= 1'b1;
      if (rd) begin
        unique case (cmd.code)
          CMD_UV_RESP: rsp_data <= {8'h00, uv_resp};
          CMD_OC_LIMIT: rsp_data <= oc_limit;
          CMD_UC_LIMIT: rsp_data <= uc_limit;
          CMD_OT_LIMIT: rsp_data <= ot_limit;
          CMD_OT_RESP: rsp_data <= {8'h00, ot_resp};
          CMD_WARN_LIMIT: rsp_data <= warn_limit;
          default: rsp_data <= '0;
        endcase
      end
    end
  end

  // Undervoltage pin synchroniser
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      uv_meta <= 1'b0;
      uv_sync <= 1'b0;
    end else begin
      uv_meta <= vout_uv_pin;
      uv_sync <= uv_meta;
    end
  end

  // Undervoltage only counts while enabled and not ramping
  assign uv_fault = uv_sync && !out_ramping && out_enable && out_enable_req;

  // Current comparisons in fixed point
  assign ifix = lin_to_fix(iout_sample);
  assign tfix = lin_to_fix(temp_sample);
  assign oc_exceed = ifix > lin_to_fix(oc_limit);
  assign uc_exceed = ifix < lin_to_fix(uc_limit);

  flru_sample_filt #(.CW(CNT_W)) u_oc_filt (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .sample_valid(iout_valid),
    .blank_done(blank_done),
    .exceed(oc_exceed),
    .need(oc_sample_count),
    .trip(oc_trip)
  );

  flru_sample_filt #(.CW(CNT_W)) u_uc_filt (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .sample_valid(iout_valid),
    .blank_done(blank_done),
    .exceed(uc_exceed),
    .need(oc_sample_count),
    .trip(uc_trip)
  );

  // Over-temperature with hysteresis down to the warning limit
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ot_active <= 1'b0;
      warn_active <= 1'b0;
    end else if (temp_valid) begin
      if (tfix > lin_to_fix(ot_limit)) ot_active <= 1'b1;
      else if (tfix < lin_to_fix(warn_limit)) ot_active <= 1'b0;
      warn_active <= tfix > lin_to_fix(warn_limit);
    end
  end

  // Device restart on a fresh enable request
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) req_q <= 1'b0;
    else req_q <= out_enable_req;
  end
  assign restart = out_enable_req && !req_q;

  flru_resp_seq #(.UNIT_CYC(UV_UNIT_CYC)) u_uv_seq (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .fault(uv_fault),
    .restart(restart),
    .resp(uv_resp),
    .run_ok(uv_ok)
  );

  flru_resp_seq #(.UNIT_CYC(OT_UNIT_CYC)) u_ot_seq (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .fault(ot_active),
    .restart(restart),
    .resp(ot_resp),
    .run_ok(ot_ok)
  );

  // Output enable from request and both sequencers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) out_enable <= 1'b0;
    else out_enable <= out_enable_req && uv_ok && ot_ok;
  end

  // Sticky status: a new event beats the clear
  always_comb begin
    next_status = clear_cmd ? '0 : status;
    if (uv_fault) next_status.uv_fault = 1'b1;
    if (oc_trip) next_status.oc_fault = 1'b1;
    if (uc_trip) next_status.uc_fault = 1'b1;
    if (ot_active) next_status.ot_fault = 1'b1;
    if (warn_active) next_status.ot_warning = 1'b1;
    if (ot_active || warn_active) next_status.temperature = 1'b1;
  end

  // Status and host notification
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= '0;
      host_alert <= 1'b0;
    end else begin
      status <= next_status;
      host_alert <= |next_status;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Sticky status and clear
  status_sticky_a: assert property (
    status.ot_fault && !clear_cmd |=> status.ot_fault)
    else $error("fault bit dropped without clear");
  set_beats_clear_a: assert property (
    clear_cmd && uv_fault |=> status.uv_fault)
    else $error("event lost during clear");
  clear_empties_a: assert property (
    clear_cmd && !uv_fault && !oc_trip && !uc_trip && !ot_active && !warn_active |=> status == '0)
    else $error("clear left a status bit set");
  uv_status_a: assert property (
    uv_fault |=> status.uv_fault)
    else $error("undervoltage not recorded");
  oc_status_a: assert property (
    oc_trip |=> status.oc_fault && host_alert)
    else $error("overcurrent not recorded");
  uc_status_a: assert property (
    uc_trip |=> status.uc_fault && host_alert)
    else $error("undercurrent not recorded");

  // Temperature hysteresis and warning
  ot_hyst_a: assert property (
    ot_active && temp_valid && tfix >= lin_to_fix(warn_limit) |=> ot_active)
    else $error("overtemp cleared above warning limit");
  ot_set_a: assert property (
    temp_valid && tfix > lin_to_fix(ot_limit) |=> ot_active)
    else $error("overtemp not declared");
  ot_release_a: assert property (
    temp_valid && tfix < lin_to_fix(warn_limit) && tfix <= lin_to_fix(ot_limit) |=> !ot_active)
    else $error("overtemp kept below warning limit");
  ot_hold_a: assert property (
    !temp_valid |=> $stable(ot_active))
    else $error("overtemp moved without a sample");
  warn_notify_a: assert property (
    warn_active |=> status.ot_warning && status.temperature && host_alert)
    else $error("warning not reported");
  warn_clear_a: assert property (
    temp_valid && tfix <= lin_to_fix(warn_limit) |=> !warn_active)
    else $error("warning kept at or below limit");

  // Undervoltage masking
  uv_mask_a: assert property (
    out_ramping |-> !uv_fault)
    else $error("undervoltage seen while ramping");

  // Register answers, writes and range refusal
  answer_follows_a: assert property (
    cmd.valid |=> rsp_valid)
    else $error("request not answered");
  answer_idle_a: assert property (
    !cmd.valid |=> !rsp_valid && !rsp_err)
    else $error("answer without request");
  unknown_refused_a: assert property (
    cmd.valid && !known |=> rsp_err)
    else $error("unknown code accepted");
  uv_resp_write_a: assert property (
    wr && cmd.code == CMD_UV_RESP |=> uv_resp == 8'($past(cmd.wdata)))
    else $error("undervoltage response not written");
  uv_resp_read_a: assert property (
    rd && cmd.code == CMD_UV_RESP |=> rsp_data == {8'h00, $past(uv_resp)})
    else $error("undervoltage response read wrong");
  ot_resp_write_a: assert property (
    wr && cmd.code == CMD_OT_RESP |=> ot_resp == 8'($past(cmd.wdata)))
    else $error("overtemp response not written");
  range_refuse_a: assert property (
    wr && cmd.code == CMD_OC_LIMIT && !cur_ok |=> $stable(oc_limit) && rsp_err)
    else $error("out of range current limit taken");
  oc_limit_write_a: assert property (
    wr && cmd.code == CMD_OC_LIMIT && cur_ok |=> oc_limit == $past(cmd.wdata))
    else $error("current limit write lost");
  uc_refuse_a: assert property (
    wr && cmd.code == CMD_UC_LIMIT && !cur_ok |=> $stable(uc_limit) && rsp_err)
    else $error("out of range valley limit taken");
  ot_limit_refuse_a: assert property (
    wr && cmd.code == CMD_OT_LIMIT && !tmp_ok |=> $stable(ot_limit) && rsp_err)
    else $error("out of range overtemp limit taken");
  warn_refuse_a: assert property (
    wr && cmd.code == CMD_WARN_LIMIT && !tmp_ok |=> $stable(warn_limit) && rsp_err)
    else $error("out of range warning limit taken");

  // Current filters
  blank_gate_a: assert property (
    !blank_done |=> $stable(oc_trip))
    else $error("current filter moved during blanking");
  sample_gate_a: assert property (
    !iout_valid |=> $stable(oc_trip) && $stable(uc_trip))
    else $error("current filter moved without a sample");

  // Output enable gating
  enable_gate_a: assert property (
    !ot_ok |=> !out_enable)
    else $error("output on while overtemp response off");
  uv_gate_a: assert property (
    !uv_ok |=> !out_enable)
    else $error("output on while undervoltage response off");
  req_gate_a: assert property (
    !out_enable_req |=> !out_enable)
    else $error("output on while not requested");
  cover_ot_c: cover property (ot_active ##[1:50] !out_enable);
  cover_oc_c: cover property (oc_trip ##1 status.oc_fault);
  cover_clear_c: cover property (status.uv_fault ##1 clear_cmd ##1 !status.uv_fault);
endmodule // flru_unit

// [tb/flru_host.sv]
// Host controller model that issues register commands to the unit
`timescale 1ns/100ps
module flru_host import flru_pkg::*; (
  input wire logic sys_clk, // System clock
  output flru_cmd_t cmd, // Command to device
  input wire logic rsp_valid, // Answer strobe
  input wire logic [15:0] rsp_data, // Read data
  input wire logic rsp_err // Refusal flag
);
  // Idle until the bench asks for a transfer
  initial cmd = '0;
  // One request, answer taken one cycle later; released fields toggle
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] r, output logic e, output logic ok);
    @(negedge sys_clk);
    cmd <= {1'b1, w, c, d};
    @(negedge sys_clk);
    ok = rsp_valid;
    r = rsp_data;
    e = rsp_err;
    cmd <= {1'b0, ~w, ~c, ~d};
  endtask
endmodule // flru_host

// [tb/flru_unit_test.sv]
// Self-checking bench for the fault limit and response unit
`timescale 1ns/100ps
module flru_unit_test import flru_pkg::*;;
  logic sys_clk = 0;
  logic arst_n = 0;
  flru_cmd_t cmd;
  logic rsp_valid, rsp_err, iout_valid, blank_done, temp_valid;
  logic vout_uv_pin, out_enable_req, out_ramping, out_enable, host_alert;
  logic [15:0] rsp_data, iout_sample, temp_sample;
  logic [3:0] oc_sample_count;
  flru_status_t status;
  logic [5:0] st;
  int failures, comparisons, cycles;
  int seed = 32'h8ebf_0a79;
  int regs[int];

  flru_unit #(.UV_UNIT_CYC(4), .OT_UNIT_CYC(4)) dut (.sys_clk(sys_clk), .arst_n(arst_n), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err), .iout_sample(iout_sample),
    .iout_valid(iout_valid), .blank_done(blank_done), .oc_sample_count(oc_sample_count),
    .temp_sample(temp_sample), .temp_valid(temp_valid), .vout_uv_pin(vout_uv_pin),
    .out_enable_req(out_enable_req), .out_ramping(out_ramping), .out_enable(out_enable),
    .status(status), .host_alert(host_alert));
  flru_host host (.sys_clk(sys_clk), .cmd(cmd), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_err(rsp_err));

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;
  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  // Linear word as value times 2^16
  function automatic longint lin(input logic [15:0] w);
    int e;
    int m;
    e = $signed(w[15:11]);
    m = $signed(w[10:0]);
    return longint'(m) <<< (e + 16);
  endfunction
  // Write through the host, refusal worked out from the ranges, model updated
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] r;
    logic e, ok, bad;
    longint v;
    v = lin(d);
    bad = !regs.exists(c) && c != CMD_CLEAR_FAULTS;
    if (c == CMD_OC_LIMIT || c == CMD_UC_LIMIT) bad = v > (24 <<< 16) || v < -(24 <<< 16);
    if (c == CMD_OT_LIMIT || c == CMD_WARN_LIMIT) bad = v > (175 <<< 16) || v < 0;
    host.xfer(1'b1, c, d, r, e, ok);
    check("wr ack", 16'(ok), 16'h0001);
    check("wr err", 16'(e), 16'(bad));
    if (!bad && regs.exists(c)) regs[c] = (c == CMD_UV_RESP || c == CMD_OT_RESP) ? d[7:0] : d;
  endtask
  task automatic rd(input logic [7:0] c);
    logic [15:0] r;
    logic e, ok;
    host.xfer(1'b0, c, 16'h0000, r, e, ok);
    check("rd ack", 16'(ok), 16'h0001);
    check("rd data", r, regs.exists(c) ? 16'(regs[c]) : 16'h0000);
    check("rd err", 16'(e), 16'(!regs.exists(c)));
  endtask
  // One sample strobe, current or temperature
  task automatic samp(input logic t, input logic [15:0] w, input logic bl);
    @(negedge sys_clk);
    iout_sample <= w;
    temp_sample <= w;
    iout_valid <= !t;
    temp_valid <= t;
    blank_done <= bl;
    @(negedge sys_clk);
    iout_valid <= 1'b0;
    temp_valid <= 1'b0;
  endtask
  task automatic chk_st;
    check("status", 16'(status), 16'(st));
    check("alert", 16'(host_alert), 16'(|st));
  endtask
  task automatic en_is(input logic v);
    check("out_enable", 16'(out_enable), 16'(v));
  endtask
  task automatic wait_en(input logic v, input int lim);
    int n;
    n = 0;
    while (out_enable !== v && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    en_is(v);
  endtask
  task automatic clear;
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    st = '0;
    tick(1);
    chk_st();
  endtask
  // Undervoltage gone, device restarted, faults cleared
  task automatic fault_end;
    vout_uv_pin <= 1'b0;
    out_enable_req <= 1'b0;
    tick(1);
    out_enable_req <= 1'b1;
    tick(4);
    en_is(1'b1);
    clear();
  endtask
  // Main sequence
  initial begin
    {iout_valid, temp_valid, blank_done, vout_uv_pin, out_enable_req, out_ramping} = '0;
    iout_sample = '0;
    temp_sample = '0;
    oc_sample_count = 4'h3;
    st = '0;
    regs[8'h45] = 16'h0080;
    regs[8'h46] = 16'hdb00;
    regs[8'h4b] = 16'hdd00;
    regs[8'h4f] = 16'hebe8;
    regs[8'h50] = 16'h0080;
    regs[8'h51] = 16'heb70;
    tick(10);
    chk_st();
    en_is(1'b0);
    arst_n <= 1'b1;
    out_enable_req <= 1'b1;
    foreach (regs[k]) rd(8'(k));
    rd(8'h47);
    wr(8'h47, 16'h1234);
    repeat (4) begin
      wr(CMD_UV_RESP, 16'($random(seed)) & 16'h00ff);
      rd(CMD_UV_RESP);
      wr(CMD_OT_RESP, 16'($random(seed)) & 16'h00ff);
      rd(CMD_OT_RESP);
    end
    wr(CMD_OC_LIMIT, 16'hd280);
    wr(CMD_OC_LIMIT, 16'hdb20);
    wr(CMD_UC_LIMIT, 16'hdce0);
    wr(CMD_OT_LIMIT, 16'hf2c0);
    wr(CMD_WARN_LIMIT, 16'h07ff);
    foreach (regs[k]) rd(8'(k));
    wr(CMD_UV_RESP, 16'h0080);
    wr(CMD_OT_RESP, 16'h0080);
    en_is(1'b1);
    done("registers");
    repeat (3) samp(0, 16'hd2c0, 0);
    tick(2);
    chk_st();
    repeat (2) samp(0, 16'hd2c0, 1);
    samp(0, 16'hd280, 1);
    repeat (2) samp(0, 16'hd2c0, 1);
    tick(2);
    chk_st();
    samp(0, 16'hd2c0, 1);
    st[2] = 1'b1;
    tick(2);
    chk_st();
    repeat (3) samp(0, 16'hdce0, 1);
    st[1] = 1'b1;
    tick(2);
    chk_st();
    samp(0, 16'hd280, 1);
    clear();
    done("current");
    samp(1, 16'heb98, 0);
    st = 6'b101000;
    tick(2);
    chk_st();
    samp(1, 16'hf208, 0);
    st[4] = 1'b1;
    wait_en(0, 8);
    chk_st();
    samp(1, 16'heb98, 0);
    samp(1, 16'heb20, 0);
    clear();
    tick(20);
    en_is(1'b0);
    fault_end();
    wr(CMD_OT_RESP, 16'h00c0);
    samp(1, 16'hf208, 0);
    wait_en(0, 8);
    samp(1, 16'heb98, 0);
    tick(10);
    en_is(1'b0);
    samp(1, 16'heb20, 0);
    wait_en(1, 8);
    clear();
    wr(CMD_OT_RESP, 16'h0000);
    samp(1, 16'hf208, 0);
    st = 6'b111000;
    tick(10);
    chk_st();
    en_is(1'b1);
    samp(1, 16'heb20, 0);
    clear();
    done("temperature");
    out_ramping <= 1'b1;
    vout_uv_pin <= 1'b1;
    tick(10);
    chk_st();
    en_is(1'b1);
    out_ramping <= 1'b0;
    wait_en(0, 8);
    st[0] = 1'b1;
    tick(20);
    chk_st();
    en_is(1'b0);
    fault_end();
    wr(CMD_UV_RESP, 16'h0089);
    vout_uv_pin <= 1'b1;
    wait_en(0, 8);
    wait_en(1, 12);
    wait_en(0, 8);
    tick(30);
    en_is(1'b0);
    fault_end();
    wr(CMD_UV_RESP, 16'h00b8);
    vout_uv_pin <= 1'b1;
    repeat (3) begin
      wait_en(0, 8);
      wait_en(1, 8);
    end
    fault_end();
    wr(CMD_UV_RESP, 16'h0000);
    vout_uv_pin <= 1'b1;
    tick(15);
    en_is(1'b1);
    st[0] = 1'b1;
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    chk_st();
    fault_end();
    wr(CMD_UV_RESP, 16'h0042);
    vout_uv_pin <= 1'b1;
    tick(8);
    en_is(1'b1);
    wait_en(0, 12);
    fault_end();
    done("undervoltage");
    summarize();
  end
endmodule // flru_unit_test
